// ===== rtl/adc_channel_sequencer.v
// Purpose: channel slot sequencer for a multichannel sigma-delta converter
// Assumes: converter core answers each start with one done pulse
// Notes:   setup fields arrive flattened, setup n at bits [n*W +: W]
//          a fir conflict only blocks a fresh start from idle
//          calibration requests are taken only while idle
// Functional notes
// R1 - sixteen slots, each picks a positive and negative mux input
// R2 - enabled slots are converted automatically without host selecting each
// R3 - each visit performs a programmable count of back-to-back conversions
// R4 - programmable settling delay before conversions start on a slot
// R5 - sequencing works except FIR; FIR needs one enabled channel
// R6 - eight setups with gain, rate, filter, reference, chop, offset, gain
// R7 - five filter types: sinc5, sinc3, sinc5 average, post, FIR
// R8 - gains 0.5 through 128 plus unity precharge bypass
// R9 - main clock from internal oscillator, external input or crystal
// R10 - diagnostic slots are sequenced exactly like ordinary slots
// R11 - internal offset, system offset and system full-scale calibration
// R12 - ascending slot order up to fifteen, disabled slots skipped
// R13 - host includes slot zero whenever several slots are enabled
// R14 - reset gives continuous mode, internal clock, slot zero only
// R15 - continuous mode wraps from highest to lowest enabled slot
`include "seq_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module adc_channel_sequencer #(
  parameter NSLOT   = 16,
  parameter NSETUP  = 8,
  parameter SELW    = 5,
  parameter DLYW    = 8,
  parameter RPTW    = 8,
  parameter CALW    = 24
) (
  input  wire                    clock,
  input  wire                    rst,
  input  wire [NSLOT-1:0]        chan_enable,
  input  wire                    chan_enable_wr,
  input  wire [NSLOT*SELW-1:0]   positive_input_select,
  input  wire [NSLOT*SELW-1:0]   negative_input_select,
  input  wire [NSLOT*3-1:0]      slot_setup,
  input  wire [NSLOT*DLYW-1:0]   slot_delay,
  input  wire [NSLOT*RPTW-1:0]   slot_repeat,
  input  wire [NSETUP*4-1:0]     setup_gain,
  input  wire [NSETUP*3-1:0]     setup_filter,
  input  wire [NSETUP*11-1:0]    setup_rate,
  input  wire [NSETUP*2-1:0]     setup_ref,
  input  wire [NSETUP-1:0]       setup_chop,
  input  wire [NSETUP*CALW-1:0]  setup_offset,
  input  wire [NSETUP*CALW-1:0]  setup_gain_cal,
  input  wire [1:0]              mode,
  input  wire [1:0]              clock_source,
  input  wire                    clock_out_en,
  input  wire [1:0]              cal_request,
  input  wire                    conv_done,
  output reg                     conv_start,
  output reg  [1:0]              cal_active,
  output reg  [3:0]              cur_slot,
  output reg  [SELW-1:0]         mux_pos,
  output reg  [SELW-1:0]         mux_neg,
  output reg  [3:0]              cur_gain,
  output reg  [2:0]              cur_filter,
  output reg  [10:0]             cur_rate,
  output reg  [1:0]              cur_ref,
  output reg                     cur_chop,
  output reg  [CALW-1:0]         cur_offset,
  output reg  [CALW-1:0]         cur_gain_cal,
  output reg                     osc_enable,
  output reg  [1:0]              clock_select,
  output reg                     clock_pin_en,
  output reg                     fir_config_error,
  output reg                     busy
);
  // sequencer states, binary coded
  localparam ST_IDLE   = 3'h0;
  localparam ST_SELECT = 3'h1;
  localparam ST_SETTLE = 3'h2;
  localparam ST_START  = 3'h3;
  localparam ST_WAIT   = 3'h4;
  localparam ST_CAL    = 3'h5;
  // settle unit in clock cycles, sized to match the unit counter
  localparam [15:0] UNIT_CYC = `DELAY_UNIT_CYC;

  // next enabled slot strictly above 'from'; wrap flag when none
  function [4:0] next_slot;
    input [NSLOT-1:0] en;
    input [4:0]       from;
    integer i;
    begin
      // 5'h10 marks that no enabled slot lies above
      next_slot = 5'h10;
      for (i = NSLOT - 1; i >= 0; i = i - 1) begin
        if (en[i] && (i > from)) begin
          next_slot = i[4:0];
        end
      end
    end
  endfunction

  // filter code of one setup; shared by the fir check and the slot apply
  function [2:0] filter_of;
    input [NSETUP*3-1:0] filt;
    input [2:0]          su;
    begin
      filter_of = filt[su*3 +: 3];
    end
  endfunction

  // counts enabled slots, used for the single-channel FIR check
  function [4:0] count_en;
    input [NSLOT-1:0] en;
    integer i;
    begin
      count_en = 5'h00;
      for (i = 0; i < NSLOT; i = i + 1) begin
        count_en = count_en + {4'h0, en[i]};
      end
    end
  endfunction

  // sequencer state, counters and lookups
  reg [NSLOT-1:0] en_q;
  reg [2:0]       state_q;
  reg [3:0]       slot_q;
  reg [DLYW-1:0]  dly_q;
  reg [15:0]      unit_q;
  reg [RPTW-1:0]  rpt_q;
  reg [1:0]       mode_q;
  reg             single_done_q;
  reg [4:0]       first_w;
  reg [4:0]       nxt_w;
  reg [2:0]       set_w;
  reg             fir_w;
  wire [NSLOT-1:0] fir_slot_w;

  // fir on any enabled slot counts, not only on the slot last visited [R5]
  genvar g;
  generate
    for (g = 0; g < NSLOT; g = g + 1) begin : g_fir
      assign fir_slot_w[g] = en_q[g] &&
                             (filter_of(setup_filter, slot_setup[g*3 +: 3]) == `FILT_FIR);
    end
  endgenerate

  // slot lookup; diagnostic sources are just other mux codes [R10]
  always @* begin
    // slot zero first; a lone slot above zero must still be found [R12]
    if (en_q[0]) begin
      first_w = 5'h00;
    end else begin
      first_w = next_slot(en_q, 5'h00);
    end
    nxt_w = next_slot(en_q, {1'b0, slot_q}); // ascending, skips disabled [R12]
    set_w = slot_setup[slot_q*3 +: 3];
    fir_w = |fir_slot_w;
  end

  // enable mask latch; reset leaves only slot zero [R14]
  // a new mask steers the next slot choice, not the running one
  always @(posedge clock) begin
    if (rst) begin
      en_q <= `CHAN_EN_RESET;
    end else if (chan_enable_wr) begin
      en_q <= chan_enable; // several slots must include slot zero [R13]
    end
  end

  // clock source control; internal oscillator after reset [R9] [R14]
  always @(posedge clock) begin
    if (rst) begin
      osc_enable   <= 1'b1;
      clock_select <= `CLK_INTERNAL;
      clock_pin_en <= 1'b0;
    end else begin
      // code 3 is unused and falls back to the internal oscillator
      clock_select <= (clock_source == 2'h3) ? `CLK_INTERNAL : clock_source;
      osc_enable   <= (clock_source == `CLK_INTERNAL) || (clock_source == 2'h3)
                      || clock_out_en;
      clock_pin_en <= clock_out_en && (clock_source != `CLK_EXTERNAL);
    end
  end

  // fir flag: sequencing refused unless exactly one slot enabled [R5]
  always @(posedge clock) begin
    if (rst) begin
      fir_config_error <= 1'b0;
    end else begin
      fir_config_error <= fir_w && (count_en(en_q) > 5'h01);
    end
  end

  // main sequencer; a slot's setup is applied when selected [R2] [R6]
  always @(posedge clock) begin
    if (rst) begin
      state_q       <= ST_IDLE;
      slot_q        <= 4'h0;
      dly_q         <= {DLYW{1'b0}};
      unit_q        <= 16'h0000;
      rpt_q         <= {RPTW{1'b0}};
      mode_q        <= `MODE_CONTINUOUS;
      single_done_q <= 1'b0;
      conv_start    <= 1'b0;
      cal_active    <= `CAL_NONE;
      cur_slot      <= 4'h0;
      mux_pos       <= `POS_SEL_RESET;
      mux_neg       <= `NEG_SEL_RESET;
      cur_gain      <= `GAIN_RESET;
      cur_filter    <= `FILT_SINC5;
      cur_rate      <= 11'h000;
      cur_ref       <= 2'h0;
      cur_chop      <= 1'b0;
      cur_offset    <= {CALW{1'b0}};
      cur_gain_cal  <= {CALW{1'b0}};
      busy          <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      mode_q     <= mode;
      if (mode != mode_q) begin
        single_done_q <= 1'b0; // new mode restarts a single pass
      end
      case (state_q)
        ST_IDLE: begin
          // calibration first, then a pass if mode and fir check allow
          busy <= 1'b0;
          if (cal_request != `CAL_NONE) begin
            cal_active <= cal_request; // offset or full-scale calibration [R11]
            state_q    <= ST_CAL;
            busy       <= 1'b1;
            conv_start <= 1'b1;
          end else if ((mode_q == `MODE_CONTINUOUS ||
                        (mode_q == `MODE_SINGLE && !single_done_q)) &&
                       !first_w[4] && !fir_config_error) begin
            slot_q  <= first_w[3:0];
            state_q <= ST_SELECT;
            busy    <= 1'b1;
          end
        end
        ST_SELECT: begin
          // route pair and the linked setup of this slot [R1] [R6]
          cur_slot     <= slot_q;
          mux_pos      <= positive_input_select[slot_q*SELW +: SELW];
          mux_neg      <= negative_input_select[slot_q*SELW +: SELW];
          cur_gain     <= setup_gain[set_w*4 +: 4]; // codes to precharge [R8]
          cur_filter   <= filter_of(setup_filter, set_w); // five filter codes [R7]
          cur_rate     <= setup_rate[set_w*11 +: 11];
          cur_ref      <= setup_ref[set_w*2 +: 2];
          cur_chop     <= setup_chop[set_w];
          cur_offset   <= setup_offset[set_w*CALW +: CALW];
          cur_gain_cal <= setup_gain_cal[set_w*CALW +: CALW];
          dly_q        <= slot_delay[slot_q*DLYW +: DLYW];
          unit_q       <= UNIT_CYC - 16'h0001;
          rpt_q        <= slot_repeat[slot_q*RPTW +: RPTW];
          state_q      <= ST_SETTLE;
        end
        ST_SETTLE: begin
          // settling delay in microsecond units [R4]
          // a zero delay goes straight to start
          if (dly_q == {DLYW{1'b0}}) begin
            state_q <= ST_START;
          end else if (unit_q == 16'h0000) begin
            unit_q <= UNIT_CYC - 16'h0001;
            dly_q  <= dly_q - {{(DLYW-1){1'b0}}, 1'b1};
          end else begin
            unit_q <= unit_q - 16'h0001;
          end
        end
        ST_START: begin
          // one-cycle launch pulse to the converter core
          conv_start <= 1'b1;
          state_q    <= ST_WAIT;
        end
        ST_WAIT: begin
          // repeats finish before a standby request is honoured
          if (conv_done) begin
            if (rpt_q != {RPTW{1'b0}}) begin
              rpt_q   <= rpt_q - {{(RPTW-1){1'b0}}, 1'b1}; // repeat count [R3]
              state_q <= ST_START;
            end else if (mode_q == `MODE_STANDBY) begin
              state_q <= ST_IDLE; // finish the conversion, then stop
            end else if (!nxt_w[4]) begin
              slot_q  <= nxt_w[3:0];
              state_q <= ST_SELECT;
            end else if (mode_q == `MODE_CONTINUOUS) begin
              slot_q  <= first_w[3:0]; // wrap to lowest enabled [R15]
              state_q <= first_w[4] ? ST_IDLE : ST_SELECT;
            end else begin
              single_done_q <= 1'b1;
              state_q       <= ST_IDLE;
            end
          end
        end
        ST_CAL: begin
          // one conversion carries the calibration
          if (conv_done) begin
            cal_active <= `CAL_NONE;
            state_q    <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // adc_channel_sequencer
`default_nettype wire

// ===== rtl/seq_defs.vh
// Purpose: constants for the channel sequencer
// Assumes: 20 MHz system clock
// Notes:   field codes and reset values of the control ports
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH
`define SLOT_COUNT        16
`define SETUP_COUNT       8
`define CHAN_EN_RESET     16'h0001
`define POS_SEL_RESET     5'h00
`define NEG_SEL_RESET     5'h01
`define SETUP_SEL_RESET   3'h0
// filter type codes
`define FILT_SINC5        3'h0
`define FILT_SINC3        3'h1
`define FILT_SINC5_AVG    3'h2
`define FILT_POST         3'h3
`define FILT_FIR          3'h4
// gain codes; 4'h9 is unity with precharge buffer only
`define GAIN_HALF         4'h0
`define GAIN_128          4'h8
`define GAIN_PRECHARGE    4'h9
`define GAIN_RESET        4'h1
// clock source codes
`define CLK_INTERNAL      2'h0
`define CLK_EXTERNAL      2'h1
`define CLK_CRYSTAL       2'h2
// conversion modes
`define MODE_CONTINUOUS   2'h0
`define MODE_SINGLE       2'h1
`define MODE_STANDBY      2'h2
// calibration commands
`define CAL_NONE          2'h0
`define CAL_INT_OFFSET    2'h1
`define CAL_SYS_OFFSET    2'h2
`define CAL_SYS_GAIN      2'h3
// settling delay unit: 1 us expressed in cycles at 20 MHz
`define DELAY_UNIT_NS     1000
`define CLOCK_PERIOD_NS   50
`define DELAY_UNIT_CYC    (`DELAY_UNIT_NS / `CLOCK_PERIOD_NS)
`endif

// ===== tb/seq_checker_props.sv
// Purpose: port checks for the channel sequencer
// Assumes: sees only the sequencer ports
// Notes:   bound from tb_top
`timescale 1ns/10ps
`default_nettype none
module seq_checker #(
  parameter NSLOT  = 16,
  parameter NSETUP = 8,
  parameter SELW   = 5
) (
  input wire logic                    clock,
  input wire logic                    rst,
  input wire logic [NSLOT*SELW-1:0]   positive_input_select,
  input wire logic [NSLOT*SELW-1:0]   negative_input_select,
  input wire logic [NSLOT*3-1:0]      slot_setup,
  input wire logic [NSETUP*4-1:0]     setup_gain,
  input wire logic [NSETUP*3-1:0]     setup_filter,
  input wire logic [1:0]              clock_source,
  input wire logic                    conv_start,
  input wire logic [3:0]              cur_slot,
  input wire logic [SELW-1:0]         mux_pos,
  input wire logic [SELW-1:0]         mux_neg,
  input wire logic [3:0]              cur_gain,
  input wire logic [2:0]              cur_filter,
  input wire logic                    osc_enable,
  input wire logic [1:0]              clock_select,
  input wire logic                    fir_config_error,
  input wire logic                    busy
);
  // setup linked to the slot now applied
  wire logic [2:0] su = slot_setup[cur_slot*3 +: 3];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence launch_s; conv_start; endsequence
  sequence slot_step_s; !rst ##1 cur_slot != $past(cur_slot) && cur_slot != 4'h0; endsequence
  reset_state_a: assert property (disable iff (1'b0) rst |=>
    cur_slot == 4'h0 && mux_pos == 5'h00 && mux_neg == 5'h01 && !busy && !conv_start
    && osc_enable && clock_select == 2'h0) else $error("reset state wrong");
  start_pulse_a: assert property (launch_s |=> !conv_start)
    else $error("start longer than one cycle");
  idle_start_a: assert property (!busy |-> !conv_start)
    else $error("start while idle");
  fir_block_a: assert property (fir_config_error && !busy |=> !busy)
    else $error("sequencing with fir conflict");
  mux_apply_a: assert property (launch_s |->
    mux_pos == positive_input_select[cur_slot*SELW +: SELW]
    && mux_neg == negative_input_select[cur_slot*SELW +: SELW]) else $error("mux mismatch");
  setup_apply_a: assert property (launch_s |->
    cur_gain == setup_gain[su*4 +: 4] && cur_filter == setup_filter[su*3 +: 3])
    else $error("setup mismatch");
  clock_pick_a: assert property (!rst |=> clock_select ==
    (($past(clock_source) == 2'h3) ? 2'h0 : $past(clock_source))) else $error("clock select");
  slot_order_a: assert property (slot_step_s |-> cur_slot > $past(cur_slot))
    else $error("slot order");
endmodule // seq_checker
`default_nettype wire

// ===== tb/conv_core_model.sv
// Purpose: converter core stand-in
// Assumes: one done pulse per start
// Notes:   fixed latency, restart on a new start
`timescale 1ns/10ps
`default_nettype none
module conv_core_model #(
  parameter int LAT = 6
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic conv_start,
  output var logic conv_done
);
  int cnt;
  // count down from start, pulse done on the last cycle
  always @(posedge clock) begin
    conv_done <= 1'b0;
    if (rst) cnt <= 0;
    else if (conv_start) cnt <= LAT;
    else if (cnt > 0) begin
      cnt <= cnt - 1;
      conv_done <= (cnt == 1);
    end
  end
endmodule // conv_core_model
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the channel sequencer
// Assumes: core model answers each start after a fixed latency
// Notes:   mode held in standby while the mask loads; reset mode_q is continuous, so the pass leaves idle on slot 0 before the mask write lands
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic         clock = 1'b0, rst = 1'b1, chan_enable_wr = 1'b0, clock_out_en = 1'b0;
  logic [15:0]  chan_enable = 16'h0000;
  logic [79:0]  pos_sel = '0, neg_sel = '0;
  logic [47:0]  slot_setup = '0;
  logic [127:0] slot_delay = '0, slot_repeat = '0;
  logic [31:0]  setup_gain = '0;
  logic [23:0]  setup_filter = '0;
  logic [87:0]  setup_rate = '0;
  logic [15:0]  setup_ref = '0;
  logic [7:0]   setup_chop = '0;
  logic [191:0] setup_offset = '0, setup_gain_cal = '0;
  logic [1:0]   mode = 2'h2, clock_source = 2'h0, cal_request = 2'h0;
  wire logic    conv_done, conv_start, osc_enable, clock_pin_en, fir_config_error, busy;
  wire logic [1:0] cal_active, clock_select, cur_ref;
  wire logic [10:0] cur_rate;
  wire logic    cur_chop;
  wire logic [23:0] cur_offset, cur_gain_cal;
  wire logic [3:0] cur_slot, cur_gain;
  wire logic [4:0] mux_pos, mux_neg;
  wire logic [2:0] cur_filter;
  int failures = 0, samples_checked = 0, cycles = 0, n_st = 0, gap = 0, i, k;
  logic [3:0] seen_slot [0:7];
  int         seen_gap [0:7];
  int         n_all = 0, n_mark;
  logic [13:0] seen_misc;
  logic [23:0] seen_offset, seen_gcal;
  localparam logic [3:0] exp_slot [0:6] = '{4'h0, 4'h0, 4'h2, 4'h5, 4'h0, 4'h0, 4'h2};
  localparam int exp_gap [0:6] = '{0, 2, 24, 4, 4, 2, 24};
  adc_channel_sequencer i_dut (.clock(clock), .rst(rst), .chan_enable(chan_enable),
    .chan_enable_wr(chan_enable_wr), .positive_input_select(pos_sel),
    .negative_input_select(neg_sel), .slot_setup(slot_setup), .slot_delay(slot_delay),
    .slot_repeat(slot_repeat), .setup_gain(setup_gain), .setup_filter(setup_filter),
    .setup_rate(setup_rate), .setup_ref(setup_ref), .setup_chop(setup_chop),
    .setup_offset(setup_offset), .setup_gain_cal(setup_gain_cal), .mode(mode),
    .clock_source(clock_source),
    .clock_out_en(clock_out_en), .cal_request(cal_request), .conv_done(conv_done),
    .conv_start(conv_start), .cal_active(cal_active), .cur_slot(cur_slot), .mux_pos(mux_pos),
    .mux_neg(mux_neg), .cur_gain(cur_gain), .cur_filter(cur_filter), .cur_rate(cur_rate),
    .cur_ref(cur_ref), .cur_chop(cur_chop), .cur_offset(cur_offset),
    .cur_gain_cal(cur_gain_cal), .osc_enable(osc_enable),
    .clock_select(clock_select), .clock_pin_en(clock_pin_en),
    .fir_config_error(fir_config_error), .busy(busy));
  conv_core_model i_core (.clock(clock), .rst(rst), .conv_start(conv_start),
    .conv_done(conv_done));
  initial forever #25 clock = ~clock;
  // slot and spacing of the first eight starts after reset, the early slot 0 pass included; gap counts edges since done
  always @(posedge clock) begin
    gap <= conv_done ? 1 : gap + 1;
    if (conv_start) n_all <= n_all + 1;
    // setup fields applied on the slot 5 visit
    if (conv_start && cur_slot == 4'h5) begin
      seen_misc <= {cur_rate, cur_ref, cur_chop};
      seen_offset <= cur_offset;
      seen_gcal <= cur_gain_cal;
    end
    if (conv_start && n_st < 8) begin
      seen_slot[n_st] <= cur_slot;
      seen_gap[n_st] <= gap;
      n_st <= n_st + 1;
    end
  end
  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      close_out;
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_mask(input logic [15:0] m);
    @(posedge clock);
    chan_enable <= m;
    chan_enable_wr <= 1'b1;
    @(posedge clock);
    chan_enable_wr <= 1'b0;
  endtask
  task automatic wait_idle;
    for (int j = 0; j < 600 && busy !== 1'b0; j++) @(negedge clock);
  endtask
  task automatic close_out;
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    for (k = 0; k < 16; k++) begin
      pos_sel[k*5 +: 5] = k[4:0];
      neg_sel[k*5 +: 5] = 5'h10 + k[4:0];
      slot_setup[k*3 +: 3] = k[2:0];
      if (k < 8) begin
        setup_rate[k*11 +: 11] = 11'h400 + k[10:0];
        setup_ref[k*2 +: 2] = k[1:0];
        setup_chop[k] = k[0];
        setup_offset[k*24 +: 24] = 24'h800000 + k[23:0];
        setup_gain_cal[k*24 +: 24] = 24'h400000 + k[23:0];
      end
    end
    pos_sel[25 +: 5] = 5'h1e; // supply node on slot 5
    slot_delay[16 +: 8] = 8'h01; // one settle unit on slot 2
    slot_repeat[0 +: 8] = 8'h01; // two conversions per visit of slot 0
    setup_gain = {4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h9};
    setup_filter = {3'h0, 3'h0, 3'h3, 3'h0, 3'h0, 3'h2, 3'h0, 3'h1};
    repeat (9) @(posedge clock);
    @(negedge clock);
    chk("reset_state", {4'h0, 5'h00, 5'h01, 1'b1, 2'h0, 1'b0, 1'b0},
      {cur_slot, mux_pos, mux_neg, osc_enable, clock_select, busy, conv_start});
    @(posedge clock) rst <= 1'b0;
    wr_mask(16'h0025); // slot 0 kept in the mask
    @(posedge clock) mode <= 2'h0;
    for (i = 0; i < 2000 && n_st < 7; i++) @(negedge clock);
    for (k = 0; k < 7; k++) begin
      chk("slot", exp_slot[k], seen_slot[k]);
      if (k > 0) chk("gap", exp_gap[k], seen_gap[k]);
    end
    chk("setup_misc", {11'h405, 2'h1, 1'b1}, seen_misc);
    chk("setup_offset", 24'h800005, seen_offset);
    chk("setup_gain_cal", 24'h400005, seen_gcal);
    // fir with several slots must not run; standby around mask changes
    @(posedge clock) mode <= 2'h2;
    wait_idle;
    @(posedge clock) setup_filter <= {8{3'h4}};
    repeat (4) @(posedge clock);
    mode <= 2'h0;
    repeat (8) @(negedge clock);
    chk("fir_block", 2'b10, {fir_config_error, busy});
    @(posedge clock) mode <= 2'h2;
    wr_mask(16'h0001);
    repeat (4) @(posedge clock);
    mode <= 2'h0;
    repeat (8) @(negedge clock);
    chk("fir_single", 2'b01, {fir_config_error, busy});
    @(posedge clock) mode <= 2'h2;
    wait_idle;
    for (k = 1; k < 4; k++) begin
      @(posedge clock) cal_request <= k[1:0];
      for (i = 0; i < 20 && cal_active !== k[1:0]; i++) @(negedge clock);
      chk("cal_start", k, cal_active);
      @(posedge clock) cal_request <= 2'h0;
      for (i = 0; i < 60 && cal_active !== 2'h0; i++) @(negedge clock);
      chk("cal_end", 0, cal_active);
    end
    // single pass over one slot above zero, then the sequencer stays idle
    wr_mask(16'h0004);
    n_mark = n_all;
    @(posedge clock) mode <= 2'h1;
    repeat (4) @(negedge clock);
    wait_idle;
    repeat (40) @(negedge clock);
    chk("single_pass", {4'h2, 1'b0}, {cur_slot, busy});
    chk("single_starts", 1, n_all - n_mark);
    for (k = 0; k < 4; k++) begin
      @(posedge clock) clock_source <= k[1:0];
      clock_out_en <= (k == 3);
      repeat (3) @(negedge clock);
      chk("clock_select", (k == 3) ? 0 : k, clock_select);
      chk("clock_pin", (k == 3), clock_pin_en);
      chk("osc_enable", (k == 0 || k == 3), osc_enable);
    end
    close_out;
  end
endmodule // tb_top
bind adc_channel_sequencer seq_checker #(.NSLOT(NSLOT), .NSETUP(NSETUP), .SELW(SELW)) i_chk (
  .clock(clock), .rst(rst), .positive_input_select(positive_input_select),
  .negative_input_select(negative_input_select), .slot_setup(slot_setup),
  .setup_gain(setup_gain), .setup_filter(setup_filter), .clock_source(clock_source),
  .conv_start(conv_start), .cur_slot(cur_slot), .mux_pos(mux_pos), .mux_neg(mux_neg),
  .cur_gain(cur_gain), .cur_filter(cur_filter), .osc_enable(osc_enable),
  .clock_select(clock_select), .fir_config_error(fir_config_error), .busy(busy));
`default_nettype wire
